// ### rtl/flash_ctrl_defs.vh
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH

// ----------------------------------------
// Register indexes (byte address = index * 4)
// ----------------------------------------
`define FPE_IDX_CMD 14'h0FF8
`define FPE_IDX_PAGE 14'h0FF9
`define FPE_IDX_KHZ_HI 14'h0FFA
`define FPE_IDX_KHZ_LO 14'h0FFB

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FPE_CMD_UNLOCK1 8'h73
`define FPE_CMD_UNLOCK2 8'h8C
`define FPE_CMD_PAGE_ERASE 8'h95
`define FPE_CMD_MASS_ERASE 8'h63
`define FPE_CMD_SECT_SEL 8'h5E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPE_INFO_BIT 7
`define FPE_PAGE_MSB 6
`define FPE_PM_PAGE_MSB 15
`define FPE_PM_PAGE_LSB 9
`define FPE_PM_SECT_LSB 13
`define FPE_PAGE_SECT_LSB 4

// ----------------------------------------
// Reset and erase fill values
// ----------------------------------------
`define FPE_RST_BYTE 8'h00
`define FPE_ERASED_BYTE 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPE_KHZ_PER_MHZ 40'h00000003E8
`define FPE_PROG_TIME_US 40'h0000000028
`define FPE_PAGE_ERASE_TIME_US 40'h0000002710
`define FPE_MASS_ERASE_TIME_US 40'h0000030D40

`endif

// ### rtl/flash_program_erase_control.v
// Summary of operation
// - Debugger ignores write-protect option for operations
// - Debugger ignores sector protection for operations
// - Debugger may program any address
// - Debugger may set or clear sector bits
// - Debugger unlocks without page rewrite
// - Debugger may rewrite page while unlocked
// - Mass erase only from debugger
// - Shared address: write command, read state
// - 73H then 8CH unlock sequence
// - 95H page erase, 63H mass erase
// - 5EH selects sector register until changed
// - Unknown or misordered command locks
// - Six-bit state codes for lock states
// - Upper state bits show operation
// - State readable anytime, top bits zero
// - Page erase fills 512-byte page FFH
// - Page field matches address bits 15:9
// - Page bit 7 selects information area
// - Sector select redirects page address
// - User sets sector bits only
// - Unlocked: user programs only within page
// - Page erase completion relocks
`include "flash_ctrl_defs.vh"

module flash_program_erase_control #(
	parameter [39:0] PROG_TIME_US = `FPE_PROG_TIME_US,
	parameter [39:0] PAGE_ERASE_TIME_US = `FPE_PAGE_ERASE_TIME_US,
	parameter [39:0] MASS_ERASE_TIME_US = `FPE_MASS_ERASE_TIME_US
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire dbg_access,
	input wire write_protect_option,
	input wire pm_wr,
	input wire [15:0] pm_addr,
	input wire [7:0] pm_wdata,
	output wire pm_ready,
	output reg [15:0] flash_addr,
	output reg [7:0] flash_wdata,
	output reg flash_prog,
	output reg flash_erase_page,
	output reg flash_erase_mass,
	output wire info_area_select,
	output wire busy
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	// Busy codes keep the low bits zero; only the top three name the operation
	localparam [5:0] ST_LOCKED = 6'h00;
	localparam [5:0] ST_UNLOCK1 = 6'h01;
	localparam [5:0] ST_UNLOCK2 = 6'h02;
	localparam [5:0] ST_UNLOCKED = 6'h03;
	localparam [5:0] ST_SECT_SEL = 6'h04;
	localparam [5:0] ST_PROG = 6'h08;
	localparam [5:0] ST_PAGE_ERASE = 6'h10;
	localparam [5:0] ST_MASS_ERASE = 6'h20;

	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_CMD = 3'h1;
	localparam [2:0] SEL_PAGE = 3'h2;
	localparam [2:0] SEL_KHZ_HI = 3'h3;
	localparam [2:0] SEL_KHZ_LO = 3'h4;

	localparam [39:0] PROG_T = PROG_TIME_US;
	localparam [39:0] PAGE_T = PAGE_ERASE_TIME_US;
	localparam [39:0] MASS_T = MASS_ERASE_TIME_US;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function [2:0] reg_sel;
		input [15:0] a;
		begin
			if (a[1:0] != 2'b00)
				reg_sel = SEL_NONE;
			else if (a[15:2] == `FPE_IDX_CMD)
				reg_sel = SEL_CMD;
			else if (a[15:2] == `FPE_IDX_PAGE)
				reg_sel = SEL_PAGE;
			else if (a[15:2] == `FPE_IDX_KHZ_HI)
				reg_sel = SEL_KHZ_HI;
			else if (a[15:2] == `FPE_IDX_KHZ_LO)
				reg_sel = SEL_KHZ_LO;
			else
				reg_sel = SEL_NONE;
		end
	endfunction

	// Top three page bits name the sector; shared by erase and program checks
	function sector_locked;
		input [7:0] locks;
		input [6:0] pg;
		begin
			sector_locked = locks[pg[`FPE_PAGE_MSB:`FPE_PAGE_SECT_LSB]];
		end
	endfunction

	// Registered state and next-value pairs
	reg [5:0] state_q;
	reg [5:0] state_d;
	reg [7:0] page_q;
	reg [7:0] page_d;
	reg [7:0] sector_lock_q;
	reg [7:0] sector_lock_d;
	reg [7:0] clock_khz_high_q;
	reg [7:0] clock_khz_low_q;
	reg [39:0] elapsed_q;
	reg [39:0] target_q;
	reg [39:0] target_d;
	reg start_prog;
	reg start_page;
	reg start_mass;

	wire [2:0] sel;
	wire wr_en;
	wire [7:0] wbyte;
	wire [15:0] clock_khz_value;
	wire [39:0] khz40;
	wire op_done;
	wire user_may_page;
	wire user_may_prog;
	wire prog_take;
	wire [7:0] sector_lock_wr;

	assign sel = reg_sel(paddr);
	assign wbyte = pwdata[7:0];
	assign clock_khz_value = {clock_khz_high_q, clock_khz_low_q};
	assign khz40 = {24'h000000, clock_khz_value};
	assign busy = (state_q[5:3] != 3'b000);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Writes stall while an operation runs; the core idles anyway.
	assign pready = ~(busy & pwrite);
	assign pslverr = psel & penable & (sel == SEL_NONE);
	assign wr_en = psel & penable & pwrite & pready & (sel != SEL_NONE);

	// Read data latched at setup so reads never need a wait state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			case (sel)
				SEL_CMD: prdata <= {24'h000000, 2'b00, state_q};
				SEL_PAGE: begin
					if (state_q == ST_SECT_SEL)
						prdata <= {24'h000000, sector_lock_q};
					else
						prdata <= {24'h000000, page_q};
				end
				SEL_KHZ_HI: prdata <= {24'h000000, clock_khz_high_q};
				SEL_KHZ_LO: prdata <= {24'h000000, clock_khz_low_q};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_khz_high_q <= `FPE_RST_BYTE;
			clock_khz_low_q <= `FPE_RST_BYTE;
		end else if (wr_en) begin
			// Either byte may come first; the pair is used live at each start
			if (sel == SEL_KHZ_HI)
				clock_khz_high_q <= wbyte;
			if (sel == SEL_KHZ_LO)
				clock_khz_low_q <= wbyte;
		end
	end

	// ----------------------------------------
	// Protection checks
	// ----------------------------------------
	// Only exported; mapping the area into memory lives outside
	assign info_area_select = page_q[`FPE_INFO_BIT];

	// User permissions; the debugger bypasses both
	assign user_may_page = ~write_protect_option &
		~sector_locked(sector_lock_q, page_q[`FPE_PAGE_MSB:0]);

	assign user_may_prog = ~write_protect_option &
		(pm_addr[`FPE_PM_PAGE_MSB:`FPE_PM_PAGE_LSB] == page_q[`FPE_PAGE_MSB:0]) &
		~sector_locked(sector_lock_q, pm_addr[`FPE_PM_PAGE_MSB:`FPE_PM_PAGE_LSB]);

	// Bus write wins over a program-memory write in the same cycle
	assign pm_ready = ~busy & ~wr_en;
	// A refused program write is dropped silently, never stalled
	assign prog_take = pm_wr & pm_ready & (state_q == ST_UNLOCKED) &
		(dbg_access | user_may_prog);

	// ----------------------------------------
	// Sector lock update
	// ----------------------------------------
	// User writes may only raise a bit; the debugger writes it outright
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_lock_bit
			assign sector_lock_wr[gi] = dbg_access ? wbyte[gi] : (sector_lock_q[gi] | wbyte[gi]);
		end
	endgenerate

	// ----------------------------------------
	// Command and state sequencing
	// ----------------------------------------
	// Any surprise on the command port falls back to locked
	always @* begin
		state_d = state_q;
		page_d = page_q;
		sector_lock_d = sector_lock_q;
		start_prog = 1'b0;
		start_page = 1'b0;
		start_mass = 1'b0;
		if (wr_en && sel == SEL_CMD) begin
			case (wbyte)
				`FPE_CMD_UNLOCK1: begin
					if (state_q == ST_LOCKED || state_q == ST_SECT_SEL)
						state_d = ST_UNLOCK1;
					else
						state_d = ST_LOCKED;
				end
				`FPE_CMD_UNLOCK2: begin
					// Debugger unlock skips the page rewrite
					if (state_q == ST_UNLOCK1)
						state_d = dbg_access ? ST_UNLOCKED : ST_UNLOCK2;
					else
						state_d = ST_LOCKED;
				end
				`FPE_CMD_PAGE_ERASE: begin
					if (state_q == ST_UNLOCKED && (dbg_access || user_may_page)) begin
						state_d = ST_PAGE_ERASE;
						start_page = 1'b1;
					end else begin
						state_d = ST_LOCKED;
					end
				end
				`FPE_CMD_MASS_ERASE: begin
					if (state_q == ST_UNLOCKED && dbg_access) begin
						state_d = ST_MASS_ERASE;
						start_mass = 1'b1;
					end else begin
						state_d = ST_LOCKED;
					end
				end
				`FPE_CMD_SECT_SEL: state_d = ST_SECT_SEL;
				default: state_d = ST_LOCKED;
			endcase
		end else if (wr_en && sel == SEL_PAGE) begin
			case (state_q)
				ST_SECT_SEL: sector_lock_d = sector_lock_wr;
				ST_LOCKED: page_d = wbyte;
				ST_UNLOCK2: begin
					// Rewrite of the same page completes the user unlock
					if (wbyte == page_q)
						state_d = ST_UNLOCKED;
					else
						state_d = ST_LOCKED;
				end
				ST_UNLOCKED: begin
					// User page rewrite while unlocked is out of order
					if (dbg_access)
						page_d = wbyte;
					else
						state_d = ST_LOCKED;
				end
				default: state_d = ST_LOCKED;
			endcase
		end else if (prog_take) begin
			state_d = ST_PROG;
			start_prog = 1'b1;
		end else if (op_done) begin
			case (state_q)
				ST_PROG: state_d = ST_UNLOCKED;
				ST_PAGE_ERASE: state_d = ST_LOCKED;
				ST_MASS_ERASE: state_d = ST_LOCKED;
				default: state_d = state_q;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_LOCKED;
			page_q <= `FPE_RST_BYTE;
			// Sector locks clear here or by a debugger write; user code cannot undo them
			sector_lock_q <= `FPE_RST_BYTE;
		end else begin
			state_q <= state_d;
			page_q <= page_d;
			sector_lock_q <= sector_lock_d;
		end
	end

	// ----------------------------------------
	// Operation timer
	// ----------------------------------------
	// Elapsed us = cycles * 1000 / kHz, so compare scaled cycle count
	// against time * kHz; no divider needed. Zero kHz ends at once.
	// Limitation: a kHz change mid-operation only counts from the next start
	always @* begin
		target_d = target_q;
		if (start_prog)
			target_d = PROG_T * khz40;
		else if (start_page)
			target_d = PAGE_T * khz40;
		else if (start_mass)
			target_d = MASS_T * khz40;
	end

	assign op_done = busy & (elapsed_q >= target_q);

	// Counter only runs while busy, so it never wraps when idle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			elapsed_q <= 40'h0000000000;
			target_q <= 40'h0000000000;
		end else begin
			target_q <= target_d;
			if (start_prog | start_page | start_mass)
				elapsed_q <= 40'h0000000000;
			else if (busy & ~op_done)
				elapsed_q <= elapsed_q + `FPE_KHZ_PER_MHZ;
		end
	end

	// ----------------------------------------
	// Flash array strobes
	// ----------------------------------------
	// Registered so the array sees clean levels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_addr <= 16'h0000;
			flash_wdata <= `FPE_RST_BYTE;
			flash_prog <= 1'b0;
			flash_erase_page <= 1'b0;
			flash_erase_mass <= 1'b0;
		end else begin
			if (start_prog) begin
				flash_addr <= pm_addr;
				flash_wdata <= pm_wdata;
				flash_prog <= 1'b1;
			end else if (start_page) begin
				// Page base: low nine bits zero, whole 512-byte page to FFH
				flash_addr <= {page_q[`FPE_PAGE_MSB:0], 9'h000};
				flash_wdata <= `FPE_ERASED_BYTE;
				flash_erase_page <= 1'b1;
			end else if (start_mass) begin
				// Mass erase spans the whole array from address zero
				flash_addr <= 16'h0000;
				flash_wdata <= `FPE_ERASED_BYTE;
				flash_erase_mass <= 1'b1;
			end else if (op_done) begin
				flash_prog <= 1'b0;
				flash_erase_page <= 1'b0;
				flash_erase_mass <= 1'b0;
			end
		end
	end

endmodule // flash_program_erase_control

// ### sim/flash_ctrl_monitor.sv
module flash_ctrl_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire dbg_access,
	input wire pm_wr,
	input wire [15:0] pm_addr,
	input wire pm_ready,
	input wire [15:0] flash_addr,
	input wire [7:0] flash_wdata,
	input wire flash_prog,
	input wire flash_erase_page,
	input wire flash_erase_mass,
	input wire busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence mass_cmd;
		psel && penable && pready && pwrite && paddr == 16'h3FE0 && pwdata[7:0] == 8'h63;
	endsequence
	mass_user_a: assert property (mass_cmd ##0 !dbg_access |=> !flash_erase_mass [*3])
		else $error("mass erase from user code");
	mass_fill_a: assert property ($rose(flash_erase_mass) |-> flash_addr == 16'h0000 && flash_wdata == 8'hFF)
		else $error("mass erase address or data");
	page_fill_a: assert property ($rose(flash_erase_page) |-> flash_addr[8:0] == 9'h000 && flash_wdata == 8'hFF)
		else $error("page erase address or data");
	prog_src_a: assert property ($rose(flash_prog) |-> $past(pm_wr) && flash_addr == $past(pm_addr))
		else $error("program without matching write");
	prog_busy_a: assert property ($rose(flash_prog) |-> busy && !pm_ready)
		else $error("program not busy");
	one_op_a: assert property ($onehot0({flash_prog, flash_erase_page, flash_erase_mass}))
		else $error("two operations at once");
	op_end_a: assert property ($fell(busy) |-> !(flash_prog || flash_erase_page || flash_erase_mass))
		else $error("operation outlives busy");
	wr_stall_a: assert property (psel && penable |-> pready == !(busy && pwrite))
		else $error("write not stalled while busy");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	rd_top_a: assert property (prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
endmodule // flash_ctrl_monitor

bind flash_program_erase_control flash_ctrl_monitor u_flash_ctrl_monitor (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dbg_access, .pm_wr, .pm_addr, .pm_ready,
	.flash_addr, .flash_wdata, .flash_prog, .flash_erase_page, .flash_erase_mass, .busy);

// ### sim/core_bus_model.sv
module core_bus_model (
	input wire pclk,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
	end
	// ------
	// Register access; values read just after an edge are those the slave sampled there
	// ------
	task xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		// No cycle count assumed; only the bench watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		pwdata <= ~pwdata;
	endtask
endmodule // core_bus_model

// ### sim/tb.sv
`include "flash_ctrl_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] CMD = {`FPE_IDX_CMD, 2'h0};
	localparam logic [15:0] PG = {`FPE_IDX_PAGE, 2'h0};
	localparam logic [15:0] KL = {`FPE_IDX_KHZ_LO, 2'h0};
	localparam logic [15:0] KH = {`FPE_IDX_KHZ_HI, 2'h0};
	logic pclk = 1'h0;
	logic presetn, psel, penable, pwrite, pready, pslverr, dbg_access, write_protect_option, pm_wr, pm_ready;
	logic flash_prog, flash_erase_page, flash_erase_mass, info_area_select, busy, er;
	logic [15:0] paddr, pm_addr, flash_addr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] pm_wdata, flash_wdata;
	int bad_count = 0;
	int comparisons = 0;
	flash_program_erase_control u_flash_program_erase_control (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .dbg_access, .write_protect_option, .pm_wr, .pm_addr,
		.pm_wdata, .pm_ready, .flash_addr, .flash_wdata, .flash_prog, .flash_erase_page, .flash_erase_mass,
		.info_area_select, .busy);
	core_bus_model u_core_bus_model (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	always #2 pclk = ~pclk;
	task chk(input string n, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, exp, got);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		u_core_bus_model.xfer(1'h1, a, d, rd, er);
	endtask
	task rdc(input string n, input logic [15:0] a, input logic [7:0] exp);
		u_core_bus_model.xfer(1'h0, a, 8'h00, rd, er);
		chk(n, exp, rd[7:0]);
	endtask
	task pm(input logic [15:0] a, input logic exp);
		@(posedge pclk);
		pm_wr <= 1'h1;
		pm_addr <= a;
		pm_wdata <= 8'h5A;
		do begin
			@(posedge pclk);
		end while (pm_ready !== 1'h1);
		pm_wr <= 1'h0;
		@(negedge pclk);
		chk("prog", {7'h00, exp}, {7'h00, flash_prog});
		if (exp) begin
			chk("prog_data", 8'h5A, flash_wdata);
			chk("prog_page", {1'h0, a[15:9]}, {1'h0, flash_addr[15:9]});
			chk("prog_addr", a[7:0], flash_addr[7:0]);
		end
	endtask
	task mode(input logic d, input logic w);
		@(posedge pclk);
		dbg_access <= d;
		write_protect_option <= w;
	endtask
	task wait_idle;
		while (busy !== 1'h0)
			@(negedge pclk);
	endtask
	task unlock(input logic [7:0] p, input logic [7:0] fin);
		wr(CMD, 8'h00);
		wr(PG, p);
		wr(CMD, 8'h73);
		rdc("state", CMD, 8'h01);
		wr(CMD, 8'h8C);
		rdc("state", CMD, fin);
	endtask
	task t_sector;
		rdc("state", CMD, 8'h00);
		rdc("khz", KL, 8'h00);
		// 20 kHz, the lowest legal clock: mass erase then takes about 4000 cycles
		wr(KH, 8'h00);
		wr(KL, 8'h14);
		rdc("khz", KL, 8'h14);
		rdc("khz", KH, 8'h00);
		u_core_bus_model.xfer(1'h0, 16'h0100, 8'h00, rd, er);
		chk("slverr", 8'h01, {7'h00, er});
		wr(PG, 8'h85);
		@(negedge pclk);
		chk("info", 8'h01, {7'h00, info_area_select});
		wr(CMD, 8'h5E);
		rdc("state", CMD, 8'h04);
		wr(PG, 8'h03);
		rdc("lock", PG, 8'h03);
		mode(1'h1, 1'h0);
		wr(PG, 8'h00);
		rdc("lock", PG, 8'h00);
		mode(1'h0, 1'h0);
		wr(PG, 8'h01);
		wr(PG, 8'h00);
		rdc("lock", PG, 8'h01);
		wr(CMD, 8'h00);
		rdc("page", PG, 8'h85);
	endtask
	task t_user;
		unlock(8'h22, 8'h02);
		wr(PG, 8'h22);
		rdc("state", CMD, 8'h03);
		pm({7'h23, 9'h000}, 1'h0);
		mode(1'h0, 1'h1);
		pm({7'h22, 9'h004}, 1'h0);
		mode(1'h0, 1'h0);
		pm({7'h22, 9'h010}, 1'h1);
		wait_idle;
		wr(CMD, 8'h95);
		@(negedge pclk);
		chk("page_erase", 8'h01, {7'h00, flash_erase_page});
		rdc("state", CMD, 8'h10);
		wait_idle;
		rdc("state", CMD, 8'h00);
	endtask
	task t_order;
		wr(CMD, 8'h73);
		wr(CMD, 8'h95);
		rdc("state", CMD, 8'h00);
		unlock(8'h01, 8'h02);
		wr(PG, 8'h01);
		wr(CMD, 8'h11);
		rdc("state", CMD, 8'h00);
		unlock(8'h01, 8'h02);
		wr(PG, 8'h01);
		wr(CMD, 8'h63);
		rdc("state", CMD, 8'h00);
		pm({7'h01, 9'h000}, 1'h0);
	endtask
	task t_debug;
		mode(1'h1, 1'h1);
		unlock(8'h04, 8'h03);
		wr(PG, 8'h05);
		rdc("state", CMD, 8'h03);
		pm({7'h02, 9'h001}, 1'h1);
		wait_idle;
		wr(CMD, 8'h63);
		@(negedge pclk);
		chk("mass_erase", 8'h01, {7'h00, flash_erase_mass});
		rdc("state", CMD, 8'h20);
		wait_idle;
		rdc("state", CMD, 8'h00);
		mode(1'h0, 1'h0);
	endtask
	task stop_test;
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		stop_test;
	end
	initial begin
		presetn = 1'h0;
		dbg_access = 1'h0;
		write_protect_option = 1'h0;
		pm_wr = 1'h0;
		pm_addr = 16'h0000;
		pm_wdata = 8'h00;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_sector;
		t_user;
		t_order;
		t_debug;
		stop_test;
	end
endmodule // tb
